// ===== src/security_supervisor_mode_control.sv
// security supervisor: alarms, stack limits, memory checks and cpu mode sequencer
`timescale 1ns/1ns
`default_nettype none
module security_supervisor_mode_control (
   input  wire  logic                                      clk,
   input  wire  logic                                      arst_n,
   // environmental sensors: voltage, frequency, temperature, light
   input  wire  logic [supervisor_pkg::sens_w-1:0]         sensor_alarm,
   // fault detectors: pc, sp, status high, block cipher a/b, bignum unit
   input  wire  logic [supervisor_pkg::fault_w-1:0]        fault_alarm,
   input  wire  logic                                      ee_light_a,
   input  wire  logic                                      ee_light_b,
   input  wire  logic [1:0]                                ee_light_sel,
   input  wire  logic                                      inv_ecc_en,
   input  wire  logic                                      ee_rd,
   input  wire  logic [supervisor_pkg::ee_code_w-1:0]      ee_rd_code,
   input  wire  logic                                      ee_wr,
   input  wire  logic                                      hv_ok,
   input  wire  logic                                      rom_rd,
   input  wire  logic [8:0]                                rom_rd_word,
   input  wire  logic                                      sp_push,
   input  wire  logic [supervisor_pkg::sp_w-1:0]           sp_value,
   input  wire  logic                                      sp_lim_wr,
   input  wire  logic [supervisor_pkg::sp_w-1:0]           sp_lim_wdata,
   input  wire  logic                                      super_system_select_bit,
   input  wire  logic                                      user_mode_req,
   input  wire  logic                                      test_done,
   input  wire  logic                                      fuse_test_avail,
   input  wire  logic                                      fuse_delivery_lock,
   input  wire  logic                                      ext_reset_req,
   input  wire  logic                                      exc_ack,
   output var   logic                                      chip_reset,
   output var   logic                                      exc_req,
   output var   logic [supervisor_pkg::xc_w-1:0]           exc_cause,
   output var   logic [supervisor_pkg::rc_w-1:0]           reset_cause,
   output var   logic                                      hv_check,
   output var   logic                                      ee_rd_valid,
   output var   logic [supervisor_pkg::ee_data_w-1:0]      ee_rd_data,
   output var   logic [2:0]                                cpu_mode,
   output var   logic                                      sensors_on
);
   import supervisor_pkg::*;

   // whole block state in one record
   typedef struct packed {
      logic [sens_w-1:0]           sens_s1;
      logic [sens_w-1:0]           sens_s2;
      logic [sens_w-1:0]           sens_s3;
      logic                        lock_s1;
      logic                        lock_s2;
      logic                        lock_s3;
      logic                        test_s1;
      logic                        test_s2;
      logic                        test_s3;
      logic                        fill_s1;
      logic                        fill_s2;
      logic                        fill_s3;
      logic                        fuse_lock;
      logic                        fuse_test;
      logic                        fuses_taken;
      cpu_mode_e                   mode;
      logic                        boot_done;
      logic [3:0]                  boot_cnt;
      logic [sp_banks-1:0][sp_w-1:0] sp_lim;
      logic                        rst_out;
      logic                        exc;
      logic [xc_w-1:0]             xcause;
      logic [rc_w-1:0]             rcause;
      logic                        hv;
      logic                        rd_valid;
      logic [ee_data_w-1:0]        rd_data;
      logic                        sens_en;
   } state_s;

   state_s q, d;

   logic [fault_w-1:0]  fault_hit;
   logic                ee_light_hit;
   logic                ecc_err;
   logic [ee_data_w-1:0] ecc_fixed;
   logic [3:0]          syndrome;
   logic [sp_banks-1:0] sp_hit;
   logic                sens_hit;
   logic                parity_hit;
   logic                any_reset;
   logic [xc_w-1:0]     exc_new;
   logic [1:0]          sp_bank;
   logic                fuse_settled;

   // positions of data bits inside the hamming codeword, 1-based
   localparam logic [3:0] dpos [ee_data_w] = '{4'h3, 4'h5, 4'h6, 4'h7,
                                              4'h9, 4'ha, 4'hb, 4'hc};

   // RL12 single error correction, one decoder per byte
   always_comb begin
      syndrome = 4'h0;
      for (int i = 1; i <= ee_code_w; i++) begin
         if (ee_rd_code[i-1]) begin
            syndrome = syndrome ^ 4'(i);
         end
      end
   end

   // RL12 flip data bit
   genvar g;
   generate
      for (g = 0; g < ee_data_w; g++) begin : g_fix
         assign ecc_fixed[g] = ee_rd_code[dpos[g]-1] ^ (syndrome == dpos[g]);
      end
   endgenerate

   assign ecc_err = ee_rd && (syndrome != 4'h0);

   // RL3 fault detector coverage
   assign fault_hit = fault_alarm;

   // RL4 selected detector only
   always_comb begin
      case (ee_light_sel)
         ee_sel_a: ee_light_hit = ee_light_a;
         ee_sel_b: ee_light_hit = ee_light_b;
         default:  ee_light_hit = 1'b0;
      endcase
   end

   // RL10 bank follows current mode
   always_comb begin
      case (q.mode)
         mode_user:   sp_bank = 2'(bank_user);
         mode_system: sp_bank = 2'(bank_sys);
         default:     sp_bank = 2'(bank_super);
      endcase
   end

   // RL10 RL20 per-bank limit compare
   generate
      for (g = 0; g < sp_banks; g++) begin : g_sp
         assign sp_hit[g] = sp_push && (sp_bank == 2'(g)) && (sp_value >= q.sp_lim[g]);
      end
   endgenerate

   // RL8 sensors gated only in test mode; no software input reaches this
   assign sens_hit   = (q.mode != mode_test) && (q.sens_s2 & q.sens_s3) != '0;
   // RL13 odd parity over rom byte
   assign parity_hit = rom_rd && (^rom_rd_word) == 1'b0;
   assign any_reset  = sens_hit || parity_hit || ext_reset_req;

   // RL19 fuse stages settled; fill marks keep reset zeros from passing as unlocked fuses
   assign fuse_settled = q.fill_s3 && (q.lock_s2 == q.lock_s3) && (q.test_s2 == q.test_s3);

   // RL2 RL9 hard-wired mapping of every exception alarm
   always_comb begin
      exc_new            = '0;
      exc_new[xc_ee_lite] = ee_light_hit;
      exc_new[xc_fault]   = |fault_hit;
      // RL5 ecc error raises exception
      exc_new[xc_ecc]     = ecc_err && inv_ecc_en;
      exc_new[xc_sp_usr]  = sp_hit[bank_user];
      exc_new[xc_sp_sys]  = sp_hit[bank_sys];
      exc_new[xc_sp_sup]  = sp_hit[bank_super];
   end

   // next state
   always_comb begin
      d = q;
      // sensor inputs pass three stages; a change counts once stages two and three agree
      d.sens_s1 = sensor_alarm;
      d.sens_s2 = q.sens_s1;
      d.sens_s3 = q.sens_s2;
      d.lock_s1 = fuse_delivery_lock;
      d.lock_s2 = q.lock_s1;
      d.lock_s3 = q.lock_s2;
      d.test_s1 = fuse_test_avail;
      d.test_s2 = q.test_s1;
      d.test_s3 = q.test_s2;
      // fill marks run in step with the fuse stages so only real samples are ever caught
      d.fill_s1 = 1'b1;
      d.fill_s2 = q.fill_s1;
      d.fill_s3 = q.fill_s2;
      d.rd_valid = ee_rd;
      if (ee_rd) begin
         d.rd_data = ecc_fixed;
      end
      // RL11 sample voltage check, no event
      if (ee_wr) begin
         d.hv = hv_ok;
      end
      // RL19 fuses caught once after reset, no software path
      if (!q.fuses_taken && fuse_settled) begin
         d.fuses_taken = 1'b1;
         d.fuse_lock   = q.lock_s3;
         d.fuse_test   = q.test_s3;
      end
      // limit write goes to the bank of the current mode
      if (sp_lim_wr) begin
         d.sp_lim[sp_bank] = sp_lim_wdata;
      end
      // RL14 boot sequencer
      case (q.mode)
         mode_boot: begin
            if (q.fuses_taken && q.boot_cnt != boot_cycles) begin
               d.boot_cnt = q.boot_cnt + 4'h1;
            end
            if (q.fuses_taken && q.boot_cnt == boot_cycles) begin
               d.boot_done = 1'b1;
               // RL16 lock bars test mode
               if (q.fuse_test && !q.fuse_lock) begin
                  d.mode = mode_test;
               end else begin
                  d.mode = mode_system;
               end
            end
         end
         mode_test: begin
            // RL15 leave test, never to boot
            if (test_done || q.fuse_lock) begin
               d.mode = mode_system;
            end
         end
         mode_system: begin
            // RL18 only legacy mode granted
            if (super_system_select_bit) begin
               d.mode = mode_legacy;
            end else if (user_mode_req) begin
               d.mode = mode_user;
            end
         end
         mode_legacy, mode_user: begin
            // RL17 exits never reach boot
            if (!super_system_select_bit && !user_mode_req) begin
               d.mode = mode_system;
            end
         end
         default: d.mode = mode_system;
      endcase
      // RL7 sticky cause, set wins over ack
      d.exc    = (q.exc && !exc_ack) || (exc_new != '0);
      d.xcause = (exc_ack ? '0 : q.xcause) | exc_new;
      d.rst_out = 1'b0;
      // RL1 RL13 reset forcing
      if (any_reset) begin
         d.rst_out = 1'b1;
         // RL21 reset beats exception
         d.exc    = 1'b0;
         d.xcause = '0;
         // RL6 record cause
         d.rcause                  = '0;
         d.rcause[rc_sensor]       = sens_hit;
         d.rcause[rc_parity]       = parity_hit;
         d.rcause[rc_ext]          = ext_reset_req;
         // RL6 RL17 return to reset values and reboot
         d.mode      = mode_boot;
         d.boot_done = 1'b0;
         d.boot_cnt  = '0;
         d.sp_lim    = '1;
         d.hv        = 1'b0;
         d.rd_valid  = 1'b0;
         d.rd_data   = '0;
      end
      // RL8 enable follows the next mode, so it moves together with cpu_mode
      d.sens_en = (d.mode != mode_test);
   end

   // register the whole state; reset values are constants only
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         q          <= '0;
         q.mode     <= mode_boot;
         q.sp_lim   <= '1;
         q.rcause   <= rc_reset_val;
         q.fuse_lock <= 1'b1;  // safest until fuses are caught
         q.sens_en   <= 1'b1;  // boot mode keeps sensors armed
      end else begin
         q <= d;
      end
   end

   // outputs come straight from the state flops
   assign chip_reset  = q.rst_out;
   assign exc_req     = q.exc;
   assign exc_cause   = q.xcause;
   assign reset_cause = q.rcause;
   assign hv_check    = q.hv;
   assign ee_rd_valid = q.rd_valid;
   assign ee_rd_data  = q.rd_data;
   assign cpu_mode    = q.mode;
   // RL8 registered enable, high outside test
   assign sensors_on  = q.sens_en;

endmodule : security_supervisor_mode_control
`default_nettype wire

// ===== src/supervisor_pkg.sv
// constants and types for the security supervisor and mode control block
// What this block does
// RL1 - out-of-range voltage, frequency, temperature or light sensor forces chip reset
// RL2 - eeprom light detector or fault detector raises an exception, not reset
// RL3 - fault detection covers pc, stack pointer, status high, ciphers, bignum unit
// RL4 - software selects one of two eeprom light detectors or none
// RL5 - inverse error correction enabled makes a detected ecc error raise exception
// RL6 - every reset restores reset values and records a readable reset cause
// RL7 - every exception leaves a readable indicator of its cause
// RL8 - sensors always enabled outside test mode; software cannot disable them
// RL9 - sensor to reset or exception mapping is fixed in hardware
// RL10 - three stack pointer limit checkers for user, system, super-system modes
// RL11 - each eeprom write samples programming voltage check into readable bit, no event
// RL12 - each eeprom byte read corrects any single-bit error automatically
// RL13 - every rom read is parity checked; parity error forces chip reset
// RL14 - start in boot mode; test mode if available, else system mode
// RL15 - test mode may go to system mode; never back to boot
// RL16 - once delivery lock is set test mode can never be entered
// RL17 - boot mode only during boot phase after reset, never re-entered
// RL18 - after test phase super-system select grants only contactless-legacy mode
// RL19 - fuse-held security enables cannot be changed by software
// RL20 - privileged-mode state registers exist per user, system, super-system mode
// RL21 - reset alarm and exception alarm together: reset wins, exception dropped
package supervisor_pkg;

   // cpu modes
   typedef enum logic [2:0] {
      mode_boot,
      mode_test,
      mode_legacy,
      mode_system,
      mode_user
   } cpu_mode_e;

   // stack pointer banks
   localparam int unsigned sp_banks   = 3;
   localparam int unsigned bank_user  = 0;
   localparam int unsigned bank_sys   = 1;
   localparam int unsigned bank_super = 2;
   localparam int unsigned sp_w       = 16;

   // reset cause bits
   localparam int unsigned rc_w       = 4;
   localparam int unsigned rc_power   = 0;
   localparam int unsigned rc_sensor  = 1;
   localparam int unsigned rc_parity  = 2;
   localparam int unsigned rc_ext     = 3;

   // exception cause bits
   localparam int unsigned xc_w       = 6;
   localparam int unsigned xc_ee_lite = 0;
   localparam int unsigned xc_fault   = 1;
   localparam int unsigned xc_ecc     = 2;
   localparam int unsigned xc_sp_usr  = 3;
   localparam int unsigned xc_sp_sys  = 4;
   localparam int unsigned xc_sp_sup  = 5;

   // sensor and fault vector widths
   localparam int unsigned sens_w     = 4;
   localparam int unsigned fault_w    = 6;

   // eeprom light-detect select codes
   localparam logic [1:0] ee_sel_off  = 2'h0;
   localparam logic [1:0] ee_sel_a    = 2'h1;
   localparam logic [1:0] ee_sel_b    = 2'h2;

   // eeprom byte with four check bits, single error correcting
   localparam int unsigned ee_data_w  = 8;
   localparam int unsigned ee_code_w  = 12;

   // boot phase length in cycles
   localparam logic [3:0] boot_cycles = 4'h8;

   // power-on value of the reset cause register
   localparam logic [rc_w-1:0] rc_reset_val = 4'h1;

endpackage : supervisor_pkg

// ===== tb/supervisor_asserts.sv
// port-level checks for the security supervisor
`timescale 1ns/1ns
`default_nettype none
module supervisor_asserts (
   input wire logic       clk,
   input wire logic       arst_n,
   input wire logic [5:0] fault_alarm,
   input wire logic       rom_rd,
   input wire logic [8:0] rom_rd_word,
   input wire logic       ee_rd,
   input wire logic       ee_wr,
   input wire logic       hv_ok,
   input wire logic       fuse_delivery_lock,
   input wire logic       ext_reset_req,
   input wire logic       exc_ack,
   input wire logic       chip_reset,
   input wire logic       exc_req,
   input wire logic [5:0] exc_cause,
   input wire logic       hv_check,
   input wire logic       ee_rd_valid,
   input wire logic [2:0] cpu_mode,
   input wire logic       sensors_on
);
   import supervisor_pkg::*;
   logic par_err;
   // an even-parity rom word is a corrupted read
   assign par_err = rom_rd && !(^rom_rd_word);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   // two cycles free of internal reset, so state may not be wiped
   sequence calm2;
      !chip_reset ##1 !chip_reset;
   endsequence
   sequence fault_only;
      fault_alarm != 6'h00 && !ext_reset_req && !chip_reset && !par_err;
   endsequence
   a_fault_raises_exc: assert property (fault_only |=> exc_req && exc_cause[xc_fault])
      else $error("fault without exception");
   a_ext_forces_reset: assert property (ext_reset_req && !chip_reset |=> chip_reset)
      else $error("external reset missing");
   a_parity_resets: assert property (par_err && !chip_reset |=> chip_reset)
      else $error("parity reset missing");
   a_reset_wins: assert property (fault_alarm != 6'h00 && ext_reset_req |=> !exc_req)
      else $error("exception beside reset");
   a_sensors_forced: assert property (sensors_on == (cpu_mode != mode_test))
      else $error("sensor enable wrong");
   a_hv_sampled: assert property (ee_wr && !chip_reset |=> hv_check == $past(hv_ok))
      else $error("hv check not sampled");
   a_boot_once: assert property ((cpu_mode != mode_boot) ##0 calm2 |-> cpu_mode != mode_boot)
      else $error("boot mode re-entered");
   a_read_valid: assert property (ee_rd |=> ee_rd_valid)
      else $error("read valid missing");
   a_exc_holds: assert property (exc_req && !exc_ack ##0 calm2 |-> exc_req)
      else $error("exception dropped early");
   a_test_locked: assert property (fuse_delivery_lock |-> cpu_mode != mode_test)
      else $error("test mode after lock");
endmodule : supervisor_asserts
bind security_supervisor_mode_control supervisor_asserts u_asserts (.clk, .arst_n, .fault_alarm,
   .rom_rd, .rom_rd_word, .ee_rd, .ee_wr, .hv_ok, .fuse_delivery_lock, .ext_reset_req, .exc_ack,
   .chip_reset, .exc_req, .exc_cause, .hv_check, .ee_rd_valid, .cpu_mode, .sensors_on);
`default_nettype wire

// ===== tb/cpu_partner.sv
// software side: acknowledges each exception after a set delay
`timescale 1ns/1ns
`default_nettype none
module cpu_partner (
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic exc_req,
   input  var  int   ack_dly,
   output var  logic exc_ack
);
   int cnt;
   // a slow handler keeps the cause visible; ack is one cycle only
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt     <= 0;
         exc_ack <= 1'b0;
      end else begin
         exc_ack <= exc_req && !exc_ack && cnt == ack_dly;
         cnt     <= (exc_req && !exc_ack) ? cnt + 1 : 0;
      end
   end
endmodule : cpu_partner
`default_nettype wire

// ===== tb/tb_top.sv
// self-checking bench for the security supervisor
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import supervisor_pkg::*;
   logic        clk, arst_n, ee_light_a, ee_light_b, inv_ecc_en, ee_rd, ee_wr, hv_ok, rom_rd;
   logic        sp_push, sp_lim_wr, super_system_select_bit, user_mode_req, test_done;
   logic        fuse_test_avail, fuse_delivery_lock, ext_reset_req, exc_ack, chip_reset;
   logic        exc_req, hv_check, ee_rd_valid, sensors_on;
   logic [3:0]  sensor_alarm, reset_cause;
   logic [5:0]  fault_alarm, exc_cause;
   logic [1:0]  ee_light_sel;
   logic [11:0] ee_rd_code;
   logic [8:0]  rom_rd_word;
   logic [15:0] sp_value, sp_lim_wdata, lim;
   logic [7:0]  ee_rd_data, d;
   logic [2:0]  cpu_mode;
   int          error_cnt, tests_run, ack_dly, f, e;
   security_supervisor_mode_control DUT (.clk, .arst_n, .sensor_alarm, .fault_alarm, .ee_light_a,
      .ee_light_b, .ee_light_sel, .inv_ecc_en, .ee_rd, .ee_rd_code, .ee_wr, .hv_ok, .rom_rd,
      .rom_rd_word, .sp_push, .sp_value, .sp_lim_wr, .sp_lim_wdata, .super_system_select_bit,
      .user_mode_req, .test_done, .fuse_test_avail, .fuse_delivery_lock, .ext_reset_req,
      .exc_ack, .chip_reset, .exc_req, .exc_cause, .reset_cause, .hv_check, .ee_rd_valid,
      .ee_rd_data, .cpu_mode, .sensors_on);
   cpu_partner sw (.clk, .arst_n, .exc_req, .ack_dly, .exc_ack);
   // 125 MHz clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic print_verdict();
      if (error_cnt == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : print_verdict
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   // bounded wait, so a stuck flag costs one mismatch and not a hang
   task automatic wait_lvl(ref logic s, input logic v);
      for (int k = 0; k < 40 && s !== v; k++) cyc(1);
      chk(s, v);
   endtask : wait_lvl
   // codeword with even parity bits at positions 1, 2, 4 and 8
   function automatic logic [11:0] enc(input logic [7:0] x);
      logic [11:0] c;
      int          k;
      c = '0;
      k = 0;
      for (int p = 3; p <= 12; p++) if (p != 4 && p != 8) c[p-1] = x[k++];
      for (int b = 0; b < 4; b++)
         for (int p = 3; p <= 12; p++) if (p[b] && p != (1 << b)) c[(1<<b)-1] ^= c[p-1];
      return c;
   endfunction : enc
   task automatic rst(input logic t, input logic l);
      @(posedge clk);
      arst_n             <= 1'b0;
      fuse_test_avail    <= t;
      fuse_delivery_lock <= l;
      test_done          <= 1'b0;
      repeat (4) @(posedge clk);
      arst_n <= 1'b1;
      cyc(20);
   endtask : rst
   // limit minus one is quiet, the limit itself must trap
   task automatic sp_case(input int b);
      lim = 16'h0100 + 16'($urandom_range(255));
      @(posedge clk);
      sp_lim_wr    <= 1'b1;
      sp_lim_wdata <= lim;
      @(posedge clk);
      sp_lim_wr <= 1'b0;
      sp_push   <= 1'b1;
      sp_value  <= lim - 16'h1;
      @(posedge clk);
      sp_value <= lim;
      #1 chk(exc_req, 0);
      @(posedge clk);
      sp_push <= 1'b0;
      #1 chk(exc_cause[b], 1);
      wait_lvl(exc_req, 1'b0);
   endtask : sp_case
   // main sequence
   initial begin
      {sensor_alarm, fault_alarm, ee_light_a, ee_light_b, ee_light_sel, inv_ecc_en, ee_rd,
       ee_rd_code, ee_wr, hv_ok, rom_rd, rom_rd_word, sp_push, sp_value, sp_lim_wr, sp_lim_wdata,
       super_system_select_bit, user_mode_req, test_done, fuse_test_avail, ext_reset_req} = '0;
      {fuse_delivery_lock, arst_n, error_cnt, tests_run, ack_dly} = {2'b10, 32'd0, 32'd0, 32'd3};
      void'($urandom(32'hc630));
      cyc(4);
      chk({reset_cause, cpu_mode}, {rc_reset_val, mode_boot});
      @(posedge clk);
      arst_n <= 1'b1;
      cyc(20);
      chk({cpu_mode, sensors_on}, {mode_system, 1'b1});
      for (int i = 0; i < 14; i++) begin
         ack_dly = 3 + $urandom_range(3);
         @(posedge clk);
         fault_alarm  <= (i < 6) ? 6'(1 << i) : 6'h00;
         ee_light_sel <= 2'(i >> 1);
         ee_light_a   <= i > 5 && i[0];
         ee_light_b   <= i > 5 && !i[0];
         @(posedge clk);
         {fault_alarm, ee_light_a, ee_light_b} <= '0;
         #1 chk(exc_cause[xc_fault], i < 6);
         chk(exc_cause[xc_ee_lite], i > 5 && (i[2:0] == 3'h3 || i[2:0] == 3'h4));
         wait_lvl(exc_req, 1'b0);
      end
      repeat (24) begin
         {d, f, e} = {8'($urandom), $urandom_range(12), $urandom_range(1)};
         @(posedge clk);
         {inv_ecc_en, ee_rd, ee_wr, hv_ok} <= {e[0], 2'b11, d[0]};
         ee_rd_code <= enc(d) ^ (12'h1 << f);
         @(posedge clk);
         {ee_rd, ee_wr, hv_ok} <= {2'b00, !d[0]};
         #1 chk({ee_rd_valid, ee_rd_data, hv_check}, {1'b1, d, d[0]});
         chk({exc_cause[xc_ecc], chip_reset}, {e == 1 && f < 12, 1'b0});
         wait_lvl(exc_req, 1'b0);
      end
      sp_case(xc_sp_sys);
      @(posedge clk);
      super_system_select_bit <= 1'b1;
      cyc(3);
      chk(cpu_mode, mode_legacy);
      sp_case(xc_sp_sup);
      @(posedge clk);
      super_system_select_bit <= 1'b0;
      cyc(3);
      user_mode_req <= 1'b1;
      cyc(3);
      chk(cpu_mode, mode_user);
      sp_case(xc_sp_usr);
      for (int p = 0; p < 2; p++) begin
         d = 8'($urandom);
         @(posedge clk);
         {rom_rd, user_mode_req} <= 2'b10;
         rom_rd_word <= {(^d) ^ p[0] ^ 1'b1, d};
         @(posedge clk);
         rom_rd <= 1'b0;
         #1 chk(chip_reset, p);
      end
      cyc(2);
      chk({reset_cause[rc_parity], cpu_mode}, {1'b1, mode_boot});
      cyc(20);
      @(posedge clk);
      {ext_reset_req, fault_alarm} <= 7'h7f;
      @(posedge clk);
      {ext_reset_req, fault_alarm} <= '0;
      #1 chk({chip_reset, exc_req, reset_cause}, {2'b10, 4'(1 << rc_ext)});
      cyc(20);
      @(posedge clk);
      sensor_alarm <= 4'(1 << $urandom_range(3));
      wait_lvl(chip_reset, 1'b1);
      sensor_alarm <= '0;
      cyc(3);
      chk(reset_cause[rc_sensor], 1);
      rst(1'b1, 1'b0);
      chk({cpu_mode, sensors_on}, {mode_test, 1'b0});
      sensor_alarm <= 4'hf;
      cyc(8);
      sensor_alarm <= '0;
      cyc(5);
      chk(reset_cause, rc_reset_val);
      test_done <= 1'b1;
      cyc(3);
      chk(cpu_mode, mode_system);
      rst(1'b1, 1'b1);
      chk(cpu_mode, mode_system);
      print_verdict();
   end
   // watchdog, far beyond the few hundred cycles the run needs
   initial begin
      #160000;
      error_cnt++;
      print_verdict();
   end
endmodule : tb_top
`default_nettype wire
